// ---- sst_pkg.sv ----
// Purpose: Shared constants for the sensor sync and trigger timing block
// Assumes: sys_clk is the master clock at 100 MHz
// Notes:   Positions count line-clock periods; latency counts sys_clk cycles
package sst_pkg;
   localparam int          LINE_W        = 12;
   localparam int          FRAME_W       = 20;
   localparam int          PIX_W         = 10;
   localparam int          FIFO_DEPTH    = 32;
   // Fixed pulse-mode sync width, in line-clock periods
   localparam logic [11:0] LINE_PULSE    = 12'h003;
   localparam logic [19:0] FRAME_PULSE   = 20'h00003;
   // Pixels per row (active columns)
   localparam logic [11:0] N_COL         = 12'h288;
   // Row trigger fall (line sync rise in master mode) to first pixel, in master clocks (at least 3)
   localparam logic [7:0]  PIX_LATENCY   = 8'h10;
   localparam logic [7:0]  LAT_WAIT_LAST = PIX_LATENCY - 8'h03;
   // Row readout states
   typedef enum logic [2:0] {
      ROW_IDLE = 3'b001,
      ROW_WAIT = 3'b010,
      ROW_SEND = 3'b100
   } sst_row_t;
endpackage : sst_pkg

// ---- sst_fifo.sv ----
// Purpose: Pixel FIFO with registered read data and valid/ready both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   No write into an empty FIFO reaches the output in the same cycle
`timescale 1ns/10ps
module sst_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             rdy_q, rdy_d, ov_q, ov_d;
   logic [WIDTH-1:0] od_q, od_d;
   logic             wr, load;

   // Pointer, count and output stage next values
   always_comb begin
      wr    = in_valid & rdy_q;
      load  = (cnt_q != '0) & (~ov_q | out_ready);
      wr_d  = wr ? AW'(wr_q + 1'b1) : wr_q;
      rd_d  = load ? AW'(rd_q + 1'b1) : rd_q;
      cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, load});
      od_d  = load ? mem[rd_q] : od_q;
      ov_d  = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
      // Output stage counts toward the depth
      rdy_d = ((AW+1)'(cnt_d + {{AW{1'b0}}, ov_d}) < (AW+1)'(DEPTH));
   end

   // Storage write
   always_ff @(posedge clk) begin
      if (wr) begin
         mem[wr_q] <= in_data;
      end
   end

   // Register state
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b0;
         od_q  <= '0;
         ov_q  <= 1'b0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
         od_q  <= od_d;
         ov_q  <= ov_d;
      end
   end

   assign in_ready  = rdy_q;
   assign out_data  = od_q;
   assign out_valid = ov_q;

   no_overflow_a: assert property (@(posedge clk) disable iff (rst)
      cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : sst_fifo

// ---- sst_sync_trig.sv ----
// Purpose: Line/frame sync generation and slave row-triggered pixel readout
// Assumes: sys_clk is the master clock; line clock arrives as a pin
// Notes:   Pin inputs pass three flops; a change counts when 2nd and 3rd agree
// Function
// [R1] In pulse mode line sync is high for 3 line clocks, then low length-3.
// [R2] In pulse mode frame sync is high for 3 line clocks, then low length-3.
// [R3] Sync edges are placed by programmable start and end positions.
// [R4] The controller holds each row trigger for at least 2 master clocks.
// [R5] First pixel of a row leaves a fixed master-clock latency after trigger.
// [R6] The controller spaces row triggers by at least latency plus columns.
// [R7] Frame trigger falls 1 to 96 master clocks after the last row trigger.
// [R8] The controller holds each frame trigger for at least 3 master clocks.
// [R9] Fixed-width pulses only in pulse mode; level mode uses start and end.
`timescale 1ns/10ps
module sst_sync_trig
   import sst_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               master_mode,
   input  wire logic               pulse_mode,
   input  wire logic [LINE_W-1:0]  line_length_clocks,
   input  wire logic [FRAME_W-1:0] frame_length_clocks,
   input  wire logic [LINE_W-1:0]  line_sync_start_pos,
   input  wire logic [LINE_W-1:0]  line_sync_end_pos,
   input  wire logic [FRAME_W-1:0] frame_sync_start_pos,
   input  wire logic [FRAME_W-1:0] frame_sync_end_pos,
   input  wire logic               line_clk_pin,
   input  wire logic               row_trig_pin,
   input  wire logic               frame_trig_pin,
   input  wire logic [PIX_W-1:0]   pix_in_data,
   input  wire logic               pix_in_valid,
   output logic                    pix_in_ready,
   output logic                    line_sync,
   output logic                    frame_sync,
   output logic      [PIX_W-1:0]   pix_out_data,
   output logic                    pix_out_valid
);
   // Level-mode window test, wrap-free
   function automatic logic in_window(input logic [FRAME_W-1:0] pos,
                                      input logic [FRAME_W-1:0] first,
                                      input logic [FRAME_W-1:0] last);
      in_window = (pos >= first) && (pos < last);
   endfunction : in_window

   // Distance from start to pos around a ring of len positions
   function automatic logic [FRAME_W-1:0] ring_dist(
      input logic [FRAME_W-1:0] pos,
      input logic [FRAME_W-1:0] first,
      input logic [FRAME_W-1:0] len);
      ring_dist = (pos >= first) ? FRAME_W'(pos - first)
                                 : FRAME_W'(pos + len - first);
   endfunction : ring_dist

   // Pin synchronisers: 0 line clock, 1 row trigger, 2 frame trigger
   logic [2:0] pin_in, s1_q, s2_q, s3_q, filt_q, filt_d;
   assign pin_in = {frame_trig_pin, row_trig_pin, line_clk_pin};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : filt_q[gi];
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               s1_q[gi]   <= 1'b0;
               s2_q[gi]   <= 1'b0;
               s3_q[gi]   <= 1'b0;
               filt_q[gi] <= 1'b0;
            end else begin
               s1_q[gi]   <= pin_in[gi];
               s2_q[gi]   <= s1_q[gi];
               s3_q[gi]   <= s2_q[gi];
               filt_q[gi] <= filt_d[gi];
            end
         end
      end
   endgenerate

   logic hclk_rise, row_fall;
   assign hclk_rise = filt_d[0] & ~filt_q[0];
   assign row_fall  = ~filt_d[1] & filt_q[1];

   // Position counters and sync levels
   logic [LINE_W-1:0]  line_pos_q, line_pos_d;
   logic [FRAME_W-1:0] frame_pos_q, frame_pos_d;
   logic               lsync_q, lsync_d, fsync_q, fsync_d;
   logic               line_pulse, frame_pulse, line_lvl, frame_lvl;
   always_comb begin
      line_pos_d  = line_pos_q;
      frame_pos_d = frame_pos_q;
      if (hclk_rise) begin
         line_pos_d  = (line_pos_q >= LINE_W'(line_length_clocks - 1'b1)) ?
                       '0 : LINE_W'(line_pos_q + 1'b1);
         frame_pos_d = (frame_pos_q >= FRAME_W'(frame_length_clocks - 1'b1))
                       ? '0 : FRAME_W'(frame_pos_q + 1'b1);
      end
      // [R1] Line pulse 3 wide, wraps at line end
      line_pulse  = ring_dist({8'h00, line_pos_d},
                              {8'h00, line_sync_start_pos},
                              {8'h00, line_length_clocks})
                    < {8'h00, LINE_PULSE};
      // [R2] Frame pulse 3 wide, wraps at frame end
      frame_pulse = ring_dist(frame_pos_d, frame_sync_start_pos,
                              frame_length_clocks) < FRAME_PULSE;
      // [R3] Programmed edge positions
      line_lvl    = in_window({8'h00, line_pos_d},
                              {8'h00, line_sync_start_pos},
                              {8'h00, line_sync_end_pos});
      frame_lvl   = in_window(frame_pos_d, frame_sync_start_pos,
                              frame_sync_end_pos);
      // [R9] Mode select for sync width
      if (master_mode) begin
         lsync_d = pulse_mode ? line_pulse : line_lvl;
         fsync_d = pulse_mode ? frame_pulse : frame_lvl;
      end else begin
         lsync_d = filt_d[1];
         fsync_d = filt_d[2];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         line_pos_q  <= '0;
         frame_pos_q <= '0;
         lsync_q     <= 1'b0;
         fsync_q     <= 1'b0;
      end else begin
         line_pos_q  <= line_pos_d;
         frame_pos_q <= frame_pos_d;
         lsync_q     <= lsync_d;
         fsync_q     <= fsync_d;
      end
   end

   // Pixel FIFO between pixel source and output bus
   logic [PIX_W-1:0] fifo_data;
   logic             fifo_valid, fifo_take;
   sst_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (sys_clk),
      .rst       (rst),
      .in_data   (pix_in_data),
      .in_valid  (pix_in_valid),
      .in_ready  (pix_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_take)
   );

   // Row readout sequencer
   sst_row_t         row_q, row_d;
   logic [7:0]       lat_q, lat_d;
   logic [11:0]      col_q, col_d;
   logic             pov_q, pov_d, row_start;
   logic [PIX_W-1:0] pod_q, pod_d;
   assign row_start = master_mode ? (lsync_d & ~lsync_q) : row_fall;
   assign fifo_take = (row_q == ROW_SEND);
   always_comb begin
      row_d = row_q;
      lat_d = lat_q;
      col_d = col_q;
      pov_d = fifo_take & fifo_valid;
      pod_d = (fifo_take & fifo_valid) ? fifo_data : pod_q;
      case (row_q)
         ROW_IDLE: begin
            // [R5] Latency counted from row trigger fall (slave) or line sync rise (master)
            if (row_start) begin
               row_d = ROW_WAIT;
               lat_d = '0;
            end
         end
         ROW_WAIT: begin
            lat_d = 8'(lat_q + 1'b1);
            if (lat_q == LAT_WAIT_LAST) begin
               row_d = ROW_SEND;
               col_d = '0;
            end
         end
         ROW_SEND: begin
            if (fifo_valid) begin
               col_d = 12'(col_q + 1'b1);
               if (col_q == 12'(N_COL - 1'b1)) begin
                  row_d = ROW_IDLE;
               end
            end
         end
         default: row_d = ROW_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         row_q <= ROW_IDLE;
         lat_q <= '0;
         col_q <= '0;
         pov_q <= 1'b0;
         pod_q <= '0;
      end else begin
         row_q <= row_d;
         lat_q <= lat_d;
         col_q <= col_d;
         pov_q <= pov_d;
         pod_q <= pod_d;
      end
   end

   assign line_sync     = lsync_q;
   assign frame_sync    = fsync_q;
   assign pix_out_data  = pod_q;
   assign pix_out_valid = pov_q;

   // Helper: line-clock rises seen while each sync is high
   logic [3:0] lcnt_q, lcnt_d, fcnt_q, fcnt_d;
   always_comb begin
      lcnt_d = lsync_q ? 4'(lcnt_q + {3'h0, hclk_rise}) : 4'h0;
      fcnt_d = fsync_q ? 4'(fcnt_q + {3'h0, hclk_rise}) : 4'h0;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lcnt_q <= '0;
         fcnt_q <= '0;
      end else begin
         lcnt_q <= lcnt_d;
         fcnt_q <= fcnt_d;
      end
   end

   // Helper: line sync settings, for settle checks
   logic [25:0] lcfg;
   assign lcfg = {master_mode, pulse_mode, line_sync_start_pos,
                  line_sync_end_pos};

   line_pulse_width_a: assert property (@(posedge sys_clk) disable iff (rst)
      master_mode && pulse_mode && $stable(master_mode) && $stable(pulse_mode)
      && lsync_q && !lsync_d && line_length_clocks > 12'h003 |->
      lcnt_d == 4'h3) else $error("line pulse not 3 line clocks"); // R1
   frame_pulse_width_a: assert property (@(posedge sys_clk) disable iff (rst)
      master_mode && pulse_mode && $stable(master_mode) && $stable(pulse_mode)
      && fsync_q && !fsync_d && frame_length_clocks > 20'h00003 |->
      fcnt_d == 4'h3) else $error("frame pulse not 3 line clocks"); // R2
   line_start_pos_a: assert property (@(posedge sys_clk) disable iff (rst)
      master_mode && $stable(master_mode) && $rose(lsync_q) &&
      $stable(lcfg) && $past(lcfg) == $past(lcfg, 2) |->
      line_pos_q == line_sync_start_pos)
      else $error("line sync rose off start position"); // R3
   level_end_pos_a: assert property (@(posedge sys_clk) disable iff (rst)
      master_mode && !pulse_mode && $stable(lcfg) &&
      line_pos_q == line_sync_end_pos |->
      !lsync_q) else $error("level line sync high at end position"); // R9
   row_latency_a: assert property (@(posedge sys_clk) disable iff (rst)
      row_q == ROW_IDLE && row_start |-> ##15 row_q == ROW_SEND ##1
      (pix_out_valid == $past(fifo_valid)))
      else $error("row readout latency wrong"); // R5
   idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
      row_q == ROW_WAIT |=> !pix_out_valid)
      else $error("pixel out during latency wait"); // R5
endmodule : sst_sync_trig

// ---- sst_ctrl_model.sv ----
// Purpose: Camera controller model: line clock, row and frame triggers
// Assumes: Triggers change on sys_clk falling edges; line clock 160 ns
// Notes:   Line clock stands low while disabled
`timescale 1ns/10ps
module sst_ctrl_model
   import sst_pkg::*;
(
   input  wire logic sys_clk,
   output logic      line_clk_pin,
   output logic      row_trig_pin,
   output logic      frame_trig_pin
);
   logic lclk_en = 1'b0;
   int   since   = 100000;

   // Line clock, phase unrelated to sys_clk
   initial begin
      line_clk_pin = 1'b0;
      row_trig_pin = 1'b0;
      frame_trig_pin = 1'b0;
      #37;
      forever #80 line_clk_pin = lclk_en ? ~line_clk_pin : 1'b0;
   end

   // Cycles since the last row trigger fall
   always @(posedge sys_clk) since <= row_trig_pin ? 0 : since + 1;

   // Row trigger once the spacing has run out
   task automatic row_pulse;
      while (since < int'(PIX_LATENCY) + int'(N_COL)) @(negedge sys_clk);
      @(negedge sys_clk);
      row_trig_pin = 1'b1;
      repeat (2) @(negedge sys_clk);
      row_trig_pin = 1'b0;
   endtask : row_pulse

   // Frame trigger, called right after the last row trigger falls
   task automatic frame_pulse(input int d);
      repeat (d) @(negedge sys_clk);
      frame_trig_pin = 1'b1;
      // three clocks high, falls within 96
      repeat (3) @(negedge sys_clk);
      frame_trig_pin = 1'b0;
   endtask : frame_pulse
endmodule : sst_ctrl_model

// ---- tb_sst_sync_trig.sv ----
// Purpose: Self-checking bench for the sync and trigger block
// Assumes: One line clock is 16 sys_clk cycles
// Notes:   Queue model of the FIFO checks every pixel out
`timescale 1ns/10ps
module tb_sst_sync_trig;
   import sst_pkg::*;
   logic               sys_clk = 1'b0, rst = 1'b1;
   logic               master_mode = 1'b1, pulse_mode = 1'b1;
   logic [LINE_W-1:0]  line_length_clocks = 12'h008;
   logic [LINE_W-1:0]  line_sync_start_pos = '0, line_sync_end_pos = '0;
   logic [FRAME_W-1:0] frame_length_clocks = 20'h0000c;
   logic [FRAME_W-1:0] frame_sync_start_pos = '0, frame_sync_end_pos = '0;
   logic               line_clk_pin, row_trig_pin, frame_trig_pin;
   logic [PIX_W-1:0]   pix_in_data = '0, pix_out_data;
   logic               pix_in_valid = 1'b0, pix_in_ready, acc = 1'b0;
   logic               line_sync, frame_sync, pix_out_valid, feed = 1'b1;
   logic [PIX_W-1:0]   q[$];
   int                 n_fail = 0, check_count = 0, pix_n = 0;

   sst_sync_trig i_sst_sync_trig (.sys_clk, .rst, .master_mode, .pulse_mode,
      .line_length_clocks, .frame_length_clocks, .line_sync_start_pos,
      .line_sync_end_pos, .frame_sync_start_pos, .frame_sync_end_pos,
      .line_clk_pin, .row_trig_pin, .frame_trig_pin, .pix_in_data,
      .pix_in_valid, .pix_in_ready, .line_sync, .frame_sync, .pix_out_data,
      .pix_out_valid);
   sst_ctrl_model i_ctrl (.sys_clk, .line_clk_pin, .row_trig_pin,
      .frame_trig_pin);

   always #5 sys_clk = ~sys_clk;

   task automatic chk_val(string what, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %0d seen %0d", what, e, g);
      end
   endtask : chk_val

   task automatic chk_pix(logic [PIX_W-1:0] e, logic [PIX_W-1:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error pixel expected %h seen %h", e, g);
      end
   endtask : chk_pix

   // FIFO model and pixel checks
   always @(posedge sys_clk) begin
      acc = pix_in_valid && pix_in_ready;
      if (acc) q.push_back(pix_in_data);
      if (pix_out_valid === 1'b1) begin
         chk_pix(q.pop_front(), pix_out_data);
         pix_n++;
      end
   end

   // Pixel source, holds a word until taken
   always @(negedge sys_clk) begin
      if (!pix_in_valid || acc) begin
         pix_in_valid <= feed;
         pix_in_data  <= PIX_W'($urandom);
      end
   end

   // Cycles until a sync output reaches level v
   task automatic wt(bit f, logic v, output int n);
      n = 0;
      while ((f ? frame_sync : line_sync) !== v && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wt

   task automatic sync_chk(bit f, int hi_e, int lo_e);
      int n, hi, lo;
      wt(f, 1'b0, n);
      wt(f, 1'b1, n);
      wt(f, 1'b0, hi);
      wt(f, 1'b1, lo);
      chk_val(f ? "frame high" : "line high", hi_e, hi);
      chk_val(f ? "frame low" : "line low", lo_e, lo);
   endtask : sync_chk

   task automatic results;
      $display("Checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   // Watchdog
   initial begin
      #300000;
      n_fail++;
      results();
   end

   // Main sequence
   initial begin
      int r, n, lat, lat0, hi, fhi;
      void'($urandom(32'ha453f342));
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      i_ctrl.lclk_en = 1'b1;
      line_sync_start_pos = 12'($urandom_range(7));
      frame_sync_start_pos = 20'($urandom_range(11));
      sync_chk(1'b0, 48, 80);
      sync_chk(1'b1, 48, 144);
      $display("Test pulse mode done");
      pulse_mode = 1'b0;
      line_sync_start_pos = 12'($urandom_range(3));
      line_sync_end_pos = line_sync_start_pos + 12'($urandom_range(5, 2));
      frame_sync_start_pos = 20'($urandom_range(5));
      frame_sync_end_pos = frame_sync_start_pos + 20'($urandom_range(6, 2));
      n = int'(line_sync_end_pos - line_sync_start_pos);
      sync_chk(1'b0, n * 16, (8 - n) * 16);
      n = int'(frame_sync_end_pos - frame_sync_start_pos);
      sync_chk(1'b1, n * 16, (12 - n) * 16);
      $display("Test level mode done");
      i_ctrl.lclk_en = 1'b0;
      master_mode = 1'b0;
      repeat (800) @(negedge sys_clk);
      chk_val("in_ready when full", 0, pix_in_ready);
      chk_val("fifo level", FIFO_DEPTH, q.size());
      pix_n = 0;
      fhi = 0;
      for (r = 0; r < 3; r++) begin
         i_ctrl.row_pulse();
         if (r == 2) fork
            i_ctrl.frame_pulse($urandom_range(90));
         join_none
         lat = 0;
         hi = 0;
         while (pix_out_valid !== 1'b1 && lat < 100) begin
            @(negedge sys_clk);
            lat++;
            hi += int'(line_sync === 1'b1);
            fhi += int'(frame_sync === 1'b1);
         end
         chk_val("row echo width", 2, hi);
         if (r == 0) lat0 = lat;
         chk_val("latency", lat0, lat);
         chk_val("latency band", 1, lat >= 16 && lat <= 22);
         // Starve the FIFO mid-row so the row must stretch
         if (r == 1) begin
            feed = 1'b0;
            repeat (60) @(negedge sys_clk);
            feed = 1'b1;
         end
         n = 0;
         while (pix_n < N_COL * (r + 1) && n < 3000) begin
            @(negedge sys_clk);
            n++;
            fhi += int'(frame_sync === 1'b1);
         end
         repeat (30) @(negedge sys_clk);
         chk_val("row pixels", N_COL * (r + 1), pix_n);
      end
      chk_val("frame echo width", 3, fhi);
      $display("Test slave rows done");
      results();
   end
endmodule : tb_sst_sync_trig
